//--- fault_mask_config_bank.sv
// module: stack role configuration and fault mask register bank
//
// Implementation choice: register access over Wishbone.
`timescale 1ns/1ns
module fault_mask_config_bank
    import fault_mask_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone classic slave
    input wire wb_req_type wb_req_i,
    output logic wb_ack_o,
    output logic [31:0] wb_dat_o,
    // fault events and pin address
    input wire byte_bank_type fault_event_i,
    input wire logic [ADDRESS_FIELD_W-1:0] pin_address_i,
    // response sequencing
    input wire logic resp_request_i,
    input wire logic upper_resp_done_i,
    output logic send_response_o,
    // configuration and fault signalling
    output logic [ADDRESS_FIELD_W-1:0] device_address_o,
    output stack_role_type role_o,
    output logic [NUM_GROUPS-1:0] fault_source_o,
    output logic fault_o
);

    ////////////////////////////////////////////////////////////////////////
    // decode helpers

    // returns the group whose mask sits at idx, or -1
    function automatic int mask_group(input logic [IDX_W-1:0] idx);
        int grp;
        grp = -1;
        for (int g = 0; g < NUM_GROUPS; g++) begin
            if (idx == MASK_IDX[g]) begin
                grp = g;
            end
        end
        return grp;
    endfunction : mask_group

    // returns the group whose status sits at idx, or -1
    function automatic int status_group(input logic [IDX_W-1:0] idx);
        int grp;
        grp = -1;
        for (int g = 0; g < NUM_GROUPS; g++) begin
            if (idx == STATUS_IDX[g]) begin
                grp = g;
            end
        end
        return grp;
    endfunction : status_group

    // read value of one register; unmapped reads as zero
    function automatic logic [7:0] read_byte(
        input bank_state_type st,
        input logic [IDX_W-1:0] idx
    );
        logic [7:0] val;
        int mg;
        int sg;
        val = 8'h00;
        mg = mask_group(idx);
        sg = status_group(idx);
        if (idx == STACK_ADDRESS_IDX) begin
            val = st.stack_address;
        end else if (idx == STACK_ROLE_CONFIG_IDX) begin
            val = st.role_config;
        end else if (mg >= 0) begin
            val = st.mask[mg];
        end else if (sg >= 0) begin
            val = st.status[sg];
        end
        return val;
    endfunction : read_byte

    ////////////////////////////////////////////////////////////////////////
    // state

    bank_state_type s_q;
    bank_state_type s_d;

    logic [IDX_W-1:0] req_idx;
    logic req_hit;
    logic req_wr;
    logic is_top;

    assign req_idx = wb_req_i.adr[13:2];
    // one access per request; the idle cycle after ack keeps it single
    assign req_hit = wb_req_i.cyc & wb_req_i.stb & ~s_q.ack;
    // data is one byte wide, so only lane 0 carries a write
    assign req_wr = req_hit & wb_req_i.we & wb_req_i.sel[0];
    assign is_top = s_q.role_config[CFG_TOP_OF_STACK_BIT];

    ////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        logic [7:0] set_bits;
        logic [7:0] clr_bits;
        int mg;
        set_bits = 8'h00;
        clr_bits = 8'h00;
        mg = mask_group(req_idx);
        s_d = s_q;
        s_d.ack = 1'b0;
        s_d.send = 1'b0;

        // sticky status: new events beat a clear in the same cycle
        for (int g = 0; g < NUM_GROUPS; g++) begin
            set_bits = fault_event_i[g] & LIVE_BITS[g];
            if (g == HOST_RX_RESPONSE_GRP
                && !s_q.role_config[CFG_MULTIDROP_BIT]) begin
                set_bits = 8'h00;
            end
            clr_bits = 8'h00;
            if (req_wr && req_idx == STATUS_IDX[g]) begin
                clr_bits = wb_req_i.dat[7:0];
            end
            s_d.status[g] = (s_q.status[g] & ~clr_bits) | set_bits;
        end

        // register writes; spare bits stored as written
        if (req_wr) begin
            if (req_idx == STACK_ADDRESS_IDX) begin
                s_d.stack_address = wb_req_i.dat[7:0];
            end else if (req_idx == STACK_ROLE_CONFIG_IDX) begin
                s_d.role_config = wb_req_i.dat[7:0];
            end else if (mg >= 0) begin
                s_d.mask[mg] = wb_req_i.dat[7:0];
            end
        end

        // read data and acknowledge, one cycle after the request
        if (req_hit) begin
            s_d.ack = 1'b1;
            s_d.rdata = {24'h00_0000, read_byte(s_q, req_idx)};
        end

        // a set mask bit hides its fault, spare bits never count
        for (int g = 0; g < NUM_GROUPS; g++) begin
            s_d.source[g] =
                |(s_q.status[g] & ~s_q.mask[g] & LIVE_BITS[g]);
        end
        s_d.fault = |s_d.source;

        // address source: pins when selected, else the register
        if (s_q.role_config[CFG_PIN_ADDRESS_SEL_BIT]) begin
            s_d.device_address = pin_address_i;
        end else begin
            s_d.device_address =
                s_q.stack_address[ADDRESS_FIELD_W-1:0];
        end

        // response sequencing: only the top skips the upper wait
        case (s_q.resp)
            RESP_IDLE: begin
                if (resp_request_i) begin
                    if (is_top) begin
                        s_d.resp = RESP_SEND;
                        s_d.send = 1'b1;
                    end else begin
                        s_d.resp = RESP_WAIT;
                    end
                end
            end
            RESP_WAIT: begin
                // top may be set while waiting; then stop waiting
                if (upper_resp_done_i || is_top) begin
                    s_d.resp = RESP_SEND;
                    s_d.send = 1'b1;
                end
            end
            RESP_SEND: begin
                s_d.resp = RESP_IDLE;
            end
            default: begin
                s_d.resp = RESP_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q <= BANK_RST;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs, all taken straight from flip-flops

    assign wb_ack_o = s_q.ack;
    assign wb_dat_o = s_q.rdata;
    assign send_response_o = s_q.send;
    assign device_address_o = s_q.device_address;
    assign fault_source_o = s_q.source;
    assign fault_o = s_q.fault;

    assign role_o.multidrop =
        s_q.role_config[CFG_MULTIDROP_BIT];
    assign role_o.pin_address_sel =
        s_q.role_config[CFG_PIN_ADDRESS_SEL_BIT];
    assign role_o.chain_member_role =
        s_q.role_config[CFG_CHAIN_MEMBER_ROLE_BIT];
    assign role_o.top_of_stack =
        s_q.role_config[CFG_TOP_OF_STACK_BIT];

endmodule : fault_mask_config_bank

//--- fault_mask_pkg.sv
// package: register map, field layout and carriers of the fault mask bank
package fault_mask_pkg;

    localparam int NUM_GROUPS = 12;
    localparam int IDX_W = 12;

    // register indices; byte address is four times the index
    localparam logic [11:0] STACK_ADDRESS_IDX = 12'h000;
    localparam logic [11:0] STACK_ROLE_CONFIG_IDX = 12'h001;
    localparam logic [11:0] PIN_FAULT_MASK_IDX = 12'h002;
    localparam logic [11:0] CELL_UNDERVOLTAGE_MASK_IDX = 12'h003;
    localparam logic [11:0] CELL_OVERVOLTAGE_MASK_IDX = 12'h004;
    localparam logic [11:0] UNDERTEMP_MASK_IDX = 12'h005;
    localparam logic [11:0] OVERTEMP_MASK_IDX = 12'h006;
    localparam logic [11:0] FAULT_TONE_MASK_IDX = 12'h007;
    localparam logic [11:0] HOST_PORT_FAULT_MASK_IDX = 12'h008;
    localparam logic [11:0] HOST_RX_COMMAND_MASK_IDX = 12'h009;
    localparam logic [11:0] HOST_RX_RESPONSE_MASK_IDX = 12'h00a;
    localparam logic [11:0] HOST_TX_RESPONSE_MASK_IDX = 12'h00b;
    localparam logic [11:0] UPPER_PORT_FAULT_MASK_IDX = 12'h00c;
    localparam logic [11:0] UPPER_RX_COMMAND_MASK_IDX = 12'h00d;
    localparam logic [11:0] PIN_STATUS_IDX = 12'h290;
    localparam logic [11:0] UNDERVOLTAGE_STATUS_IDX = 12'h291;
    localparam logic [11:0] OVERVOLTAGE_STATUS_IDX = 12'h292;
    localparam logic [11:0] UNDERTEMP_STATUS_IDX = 12'h293;
    localparam logic [11:0] OVERTEMP_STATUS_IDX = 12'h294;
    localparam logic [11:0] TONE_STATUS_IDX = 12'h295;
    localparam logic [11:0] HOST_PORT_STATUS_IDX = 12'h296;
    localparam logic [11:0] HOST_RX_COMMAND_STATUS_IDX = 12'h297;
    localparam logic [11:0] HOST_RX_RESPONSE_STATUS_IDX = 12'h298;
    localparam logic [11:0] HOST_TX_RESPONSE_STATUS_IDX = 12'h299;
    localparam logic [11:0] UPPER_PORT_STATUS_IDX = 12'h29a;
    localparam logic [11:0] UPPER_RX_COMMAND_STATUS_IDX = 12'h29b;

    localparam logic [11:0] MASK_IDX [NUM_GROUPS] = '{
        PIN_FAULT_MASK_IDX, CELL_UNDERVOLTAGE_MASK_IDX,
        CELL_OVERVOLTAGE_MASK_IDX, UNDERTEMP_MASK_IDX,
        OVERTEMP_MASK_IDX, FAULT_TONE_MASK_IDX,
        HOST_PORT_FAULT_MASK_IDX, HOST_RX_COMMAND_MASK_IDX,
        HOST_RX_RESPONSE_MASK_IDX, HOST_TX_RESPONSE_MASK_IDX,
        UPPER_PORT_FAULT_MASK_IDX, UPPER_RX_COMMAND_MASK_IDX};
    localparam logic [11:0] STATUS_IDX [NUM_GROUPS] = '{
        PIN_STATUS_IDX, UNDERVOLTAGE_STATUS_IDX,
        OVERVOLTAGE_STATUS_IDX, UNDERTEMP_STATUS_IDX,
        OVERTEMP_STATUS_IDX, TONE_STATUS_IDX,
        HOST_PORT_STATUS_IDX, HOST_RX_COMMAND_STATUS_IDX,
        HOST_RX_RESPONSE_STATUS_IDX, HOST_TX_RESPONSE_STATUS_IDX,
        UPPER_PORT_STATUS_IDX, UPPER_RX_COMMAND_STATUS_IDX};

    // group of the response status that only multi-drop keeps
    localparam int HOST_RX_RESPONSE_GRP = 8;

    // field positions
    localparam int ADDRESS_FIELD_W = 6;
    localparam int CFG_TOP_OF_STACK_BIT = 0;
    localparam int CFG_CHAIN_MEMBER_ROLE_BIT = 1;
    localparam int CFG_PIN_ADDRESS_SEL_BIT = 2;
    localparam int CFG_MULTIDROP_BIT = 3;
    localparam int TONE_RECOVERY_MASK_BIT = 2;
    localparam int HEARTBEAT_LOSS_MASK_BIT = 1;
    localparam int HEARTBEAT_OVERRATE_MASK_BIT = 0;
    localparam int LINK_CLEAR_DETECT_MASK_BIT = 2;
    localparam int LINK_RESET_DETECT_MASK_BIT = 1;
    localparam int STOP_BIT_ERROR_MASK_BIT = 0;
    localparam int FRAME_START_ERROR_MASK_BIT = 3;
    localparam int BYTE_ERROR_MASK_BIT = 2;
    localparam int CHECKSUM_ERROR_MASK_BIT = 0;
    localparam int TX_FRAME_START_MASK_BIT = 1;
    localparam int RESPONSE_TIMEOUT_MASK_BIT = 0;

    // implemented bits of each group; the rest are spare
    localparam logic [7:0] SIX_LIVE = 8'h3f;
    localparam logic [7:0] TONE_LIVE = 8'((1 << TONE_RECOVERY_MASK_BIT)
        | (1 << HEARTBEAT_LOSS_MASK_BIT)
        | (1 << HEARTBEAT_OVERRATE_MASK_BIT));
    localparam logic [7:0] HOST_PORT_LIVE = 8'(
        (1 << LINK_CLEAR_DETECT_MASK_BIT)
        | (1 << LINK_RESET_DETECT_MASK_BIT)
        | (1 << STOP_BIT_ERROR_MASK_BIT));
    localparam logic [7:0] RX_RESP_LIVE = 8'(
        (1 << FRAME_START_ERROR_MASK_BIT)
        | (1 << BYTE_ERROR_MASK_BIT)
        | (1 << CHECKSUM_ERROR_MASK_BIT));
    localparam logic [7:0] TX_RESP_LIVE = 8'(
        (1 << TX_FRAME_START_MASK_BIT)
        | (1 << RESPONSE_TIMEOUT_MASK_BIT));
    localparam logic [7:0] LIVE_BITS [NUM_GROUPS] = '{
        SIX_LIVE, SIX_LIVE, SIX_LIVE, SIX_LIVE, SIX_LIVE, TONE_LIVE,
        HOST_PORT_LIVE, SIX_LIVE, RX_RESP_LIVE, TX_RESP_LIVE,
        SIX_LIVE, SIX_LIVE};

    // reset values
    localparam logic [7:0] STACK_ADDRESS_RST = 8'h00;
    localparam logic [7:0] STACK_ROLE_CONFIG_RST = 8'h00;
    localparam logic [7:0] MASK_RST = 8'h00;
    localparam logic [7:0] STATUS_RST = 8'h00;

    typedef enum logic [1:0] {
        RESP_IDLE = 2'b00,
        RESP_WAIT = 2'b01,
        RESP_SEND = 2'b11
    } resp_state_type;

    typedef logic [NUM_GROUPS-1:0][7:0] byte_bank_type;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [13:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } wb_req_type;

    typedef struct packed {
        logic multidrop;
        logic pin_address_sel;
        logic chain_member_role;
        logic top_of_stack;
    } stack_role_type;

    typedef struct packed {
        logic [7:0] stack_address;
        logic [7:0] role_config;
        byte_bank_type mask;
        byte_bank_type status;
        logic [ADDRESS_FIELD_W-1:0] device_address;
        logic [NUM_GROUPS-1:0] source;
        logic fault;
        resp_state_type resp;
        logic send;
        logic ack;
        logic [31:0] rdata;
    } bank_state_type;

    localparam bank_state_type BANK_RST = '{
        stack_address: STACK_ADDRESS_RST,
        role_config: STACK_ROLE_CONFIG_RST,
        mask: {NUM_GROUPS{MASK_RST}},
        status: {NUM_GROUPS{STATUS_RST}},
        device_address: STACK_ADDRESS_RST[ADDRESS_FIELD_W-1:0],
        source: '0,
        fault: 1'b0,
        resp: RESP_IDLE,
        send: 1'b0,
        ack: 1'b0,
        rdata: 32'h0000_0000};

endpackage : fault_mask_pkg

//--- fault_mask_config_bank_checker.sv
// checker: bus, role, address, fault and response assertions
`timescale 1ns/1ns
module fault_mask_config_bank_checker
    import fault_mask_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // watched ports
    input wire wb_req_type wb_req_i,
    input wire logic wb_ack_o,
    input wire logic [31:0] wb_dat_o,
    input wire byte_bank_type fault_event_i,
    input wire logic [ADDRESS_FIELD_W-1:0] pin_address_i,
    input wire logic resp_request_i,
    input wire logic upper_resp_done_i,
    input wire logic send_response_o,
    input wire logic [ADDRESS_FIELD_W-1:0] device_address_o,
    input wire stack_role_type role_o,
    input wire logic [NUM_GROUPS-1:0] fault_source_o,
    input wire logic fault_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic [3:0] cfg_q;
    logic cfg_wr_q;
    wire take = wb_req_i.cyc && wb_req_i.stb && !wb_ack_o;
    wire cfg_wr = take && wb_req_i.we && wb_req_i.sel[0]
        && wb_req_i.adr[13:2] == STACK_ROLE_CONFIG_IDX;
    always_ff @(posedge clk_i) begin
        cfg_wr_q <= rst_i ? 1'b0 : cfg_wr;
        cfg_q <= cfg_wr ? wb_req_i.dat[3:0] : cfg_q;
    end
    sequence req_taken;
        take;
    endsequence
    sequence cfg_landed;
        cfg_wr_q ##1 1'b1;
    endsequence
    ////////////////////////////////////////
    a_ack_latency: assert property (req_taken |=> wb_ack_o)
        else $error("request not answered one cycle later");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_read_width: assert property (wb_ack_o |-> !(|wb_dat_o[31:8]))
        else $error("read data above byte not zero");
    a_role_follows: assert property (cfg_landed |-> role_o == cfg_q)
        else $error("role outputs differ from config write");
    a_pin_address: assert property (role_o.pin_address_sel [*3]
        |-> device_address_o == $past(pin_address_i))
        else $error("pin address not used");
    a_fault_or: assert property (fault_o == (|fault_source_o))
        else $error("fault differs from or of sources");
    a_send_pulse: assert property (send_response_o |=> !send_response_o)
        else $error("send longer than one cycle");
    a_send_cause: assert property (send_response_o
        && !$past(role_o.top_of_stack) |-> $past(upper_resp_done_i))
        else $error("send without upper response");
endmodule : fault_mask_config_bank_checker

bind fault_mask_config_bank fault_mask_config_bank_checker checker_u (
    .clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i),
    .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
    .fault_event_i(fault_event_i), .pin_address_i(pin_address_i),
    .resp_request_i(resp_request_i),
    .upper_resp_done_i(upper_resp_done_i),
    .send_response_o(send_response_o),
    .device_address_o(device_address_o), .role_o(role_o),
    .fault_source_o(fault_source_o), .fault_o(fault_o));

//--- fault_mask_config_bank_bench.sv
// bench: registers, role, address, fault masks and response
`timescale 1ns/1ns
module fault_mask_config_bank_bench;
    import fault_mask_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    wb_req_type req = '0;
    logic ack;
    logic [31:0] rdat;
    byte_bank_type ev = '0;
    logic [5:0] pin = '0;
    logic rreq = 1'b0;
    logic udone = 1'b0;
    logic send;
    logic [5:0] dev;
    stack_role_type role;
    logic [11:0] src;
    logic flt;
    int err_count = 0;
    int checks_done = 0;
    // live bits per group, spare positions left out
    logic [7:0] live_exp [12] = '{8'h3f, 8'h3f, 8'h3f, 8'h3f, 8'h3f,
        8'h07, 8'h07, 8'h3f, 8'h0d, 8'h03, 8'h3f, 8'h3f};

    fault_mask_config_bank dut_u (.clk_i(clk_i), .rst_i(rst_i),
        .wb_req_i(req), .wb_ack_o(ack), .wb_dat_o(rdat),
        .fault_event_i(ev), .pin_address_i(pin),
        .resp_request_i(rreq), .upper_resp_done_i(udone),
        .send_response_o(send), .device_address_o(dev), .role_o(role),
        .fault_source_o(src), .fault_o(flt));

    initial begin
        forever #2 clk_i = ~clk_i;
    end
    ////////////////////////////////////////
    task automatic compare(input string what, input logic [31:0] e, g);
        checks_done++;
        if (g !== e) begin
            err_count++;
            $display("BAD %s expected %h seen %h", what, e, g);
        end
    endtask : compare

    task automatic bus(input logic [11:0] idx, input logic we, sel,
        input logic [7:0] wd, output logic [31:0] rd);
        @(posedge clk_i);
        req <= '{1'b1, 1'b1, we, {idx, 2'b00}, {3'b000, sel}, {24'h0, wd}};
        // no local limit: a hung bus is ended by the watchdog
        do begin
            @(posedge clk_i);
        end while (ack !== 1'b1);
        rd = rdat;
        req <= '0;
    endtask : bus

    task automatic wr(input logic [11:0] idx, input logic [7:0] wd);
        logic [31:0] d;
        bus(idx, 1'b1, 1'b1, wd, d);
    endtask : wr

    task automatic rdchk(string nm, logic [11:0] idx, logic [7:0] e);
        logic [31:0] d;
        bus(idx, 1'b0, 1'b1, 8'h00, d);
        compare(nm, {24'h0, e}, d);
    endtask : rdchk

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : tick

    task automatic pulse(input logic done);
        @(posedge clk_i);
        if (done) udone <= 1'b1;
        else rreq <= 1'b1;
        @(posedge clk_i);
        udone <= 1'b0;
        rreq <= 1'b0;
        #1;
    endtask : pulse
    ////////////////////////////////////////
    task automatic t_regs;
        logic [31:0] d;
        for (int i = 0; i < 14; i++) begin
            rdchk("reset value", 12'(i), 8'h00);
            wr(12'(i), 8'ha5 ^ 8'(i));
            rdchk("rw byte", 12'(i), 8'ha5 ^ 8'(i));
            wr(12'(i), 8'h00);
        end
        bus(12'h000, 1'b1, 1'b0, 8'h3c, d);
        rdchk("lane off", 12'h000, 8'h00);
        wr(12'h00e, 8'hff);
        rdchk("unmapped", 12'h00e, 8'h00);
    endtask : t_regs

    task automatic t_role;
        for (int b = 0; b < 4; b++) begin
            wr(STACK_ROLE_CONFIG_IDX, 8'(1 << b) | 8'hf0);
            tick(2);
            compare("role", 32'(1 << b), {28'h0, role});
        end
    endtask : t_role

    task automatic t_addr;
        @(posedge clk_i);
        pin <= 6'h15;
        wr(STACK_ADDRESS_IDX, 8'hea);
        wr(STACK_ROLE_CONFIG_IDX, 8'h00);
        tick(2);
        compare("own address", 32'h2a, {26'h0, dev});
        wr(STACK_ROLE_CONFIG_IDX, 8'h04);
        tick(3);
        compare("pin address", 32'h15, {26'h0, dev});
    endtask : t_addr

    task automatic t_masks;
        logic [11:0] one;
        logic [11:0] st;
        wr(STACK_ROLE_CONFIG_IDX, 8'h08);
        for (int g = 0; g < NUM_GROUPS; g++) begin
            one = 12'(1) << g;
            st = 12'h290 + 12'(g);
            rdchk("status reset", st, 8'h00);
            @(posedge clk_i);
            ev[g] <= 8'hff;
            @(posedge clk_i);
            ev[g] <= 8'h00;
            tick(2);
            compare("source", {20'h0, one}, {20'h0, src});
            rdchk("status", st, live_exp[g]);
            wr(12'h002 + 12'(g), 8'hc0);
            tick(1);
            compare("spare mask", {20'h0, one}, {20'h0, src});
            wr(12'h002 + 12'(g), live_exp[g]);
            tick(1);
            compare("masked", 32'h0, {31'h0, flt});
            rdchk("kept", st, live_exp[g]);
            wr(st, 8'hff);
            wr(12'h002 + 12'(g), 8'h00);
        end
        // event on the very edge that takes the clear: event must survive
        @(posedge clk_i);
        ev[0] <= 8'h01;
        fork
            wr(PIN_STATUS_IDX, 8'hff);
            begin
                repeat (2) @(posedge clk_i);
                ev[0] <= 8'h00;
            end
        join
        rdchk("set beats clear", PIN_STATUS_IDX, 8'h01);
        wr(PIN_STATUS_IDX, 8'hff);
        rdchk("cleared", PIN_STATUS_IDX, 8'h00);
        wr(STACK_ROLE_CONFIG_IDX, 8'h00);
        @(posedge clk_i);
        ev[8] <= 8'hff;
        @(posedge clk_i);
        ev[8] <= 8'h00;
        tick(2);
        compare("no multidrop", 32'h0, {31'h0, flt});
        rdchk("no multidrop", 12'h298, 8'h00);
    endtask : t_masks

    task automatic t_resp;
        wr(STACK_ROLE_CONFIG_IDX, 8'h01);
        tick(2);
        pulse(1'b0);
        compare("top send", 32'h1, {31'h0, send});
        tick(1);
        compare("send drop", 32'h0, {31'h0, send});
        wr(STACK_ROLE_CONFIG_IDX, 8'h00);
        tick(2);
        pulse(1'b0);
        compare("waiting", 32'h0, {31'h0, send});
        tick(3);
        compare("still waiting", 32'h0, {31'h0, send});
        pulse(1'b1);
        compare("upper done", 32'h1, {31'h0, send});
        // becoming top while waiting ends the wait
        pulse(1'b0);
        wr(STACK_ROLE_CONFIG_IDX, 8'h01);
        tick(0);
        compare("top while waiting", 32'h1, {31'h0, send});
    endtask : t_resp

    task automatic summarize;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : summarize
    ////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge clk_i);
        err_count++;
        summarize;
    end

    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        #1;
        compare("rst", 32'h0, {7'h0, role, src, flt, send, dev, ack});
        compare("rst data", 32'h0, rdat);
        @(posedge clk_i);
        t_regs;
        t_role;
        t_addr;
        t_masks;
        t_resp;
        summarize;
    end
endmodule : fault_mask_config_bank_bench
